// ===== usbec_top.sv
// Endpoint settings, link timing and sleep over AXI4-Lite
module usbec_top
    import usbec_pkg::*;
#(
    parameter int NUM_EP = 4,
    parameter int IDLE_CYCLES = IDLE_CYC,
    parameter logic [3:0] RX_FIFO_CAP = 4'h3,
    parameter logic [3:0] TX_FIFO_CAP = 4'h3,
    // Identification values are arbitrary
    parameter logic VER_RC = 1'b0,
    parameter logic [4:0] VER_MAJOR = 5'h01,
    parameter logic [9:0] VER_MINOR = 10'h000,
    parameter logic [3:0] DMA_CHANS = 4'h0,
    parameter logic [3:0] RAM_BITS_M1 = 4'hB
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [usbec_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [usbec_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Transaction engine side
    input wire logic [$clog2(NUM_EP)-1:0] active_ep,
    input wire usbec_pkg::usbec_speed_t link_speed,
    input wire logic [15:0] frame_left_cyc,
    input wire logic block_pkt_done,
    output logic txn_start_allowed,
    output logic block_req_pending,
    // Selected endpoint settings
    output logic [1:0] tx_protocol,
    output logic [3:0] tx_target_ep,
    output logic [7:0] tx_poll_frames,
    output logic [7:0] tx_nak_limit,
    output logic [12:0] tx_max_packet_bytes,
    output logic [13:0] tx_buffer_bytes,
    output logic [15:0] tx_buffer_byte_addr,
    output logic [1:0] rx_protocol,
    output logic [3:0] rx_target_ep,
    output logic [7:0] rx_poll_frames,
    output logic [7:0] rx_nak_limit,
    output logic [12:0] rx_max_packet_bytes,
    output logic [13:0] rx_buffer_bytes,
    output logic [15:0] rx_buffer_byte_addr,
    // Link timing settings
    output logic [3:0] connect_filter_wait,
    output logic [3:0] id_settle_delay,
    output logic [7:0] vbus_pulse_duration,
    // Bus pins and power
    input wire logic bus_activity,
    input wire logic resume_signal,
    output logic resume_drive,
    output logic sleep_active,
    output logic suspend_indicator_out_n
);
    import usbec_pkg::*;
    localparam int EPW = $clog2(NUM_EP);

    function automatic logic [15:0] merge(input logic [15:0] old,
        input logic [31:0] wd, input logic [3:0] st);
        logic [15:0] m;
        m = {{8{st[1]}}, {8{st[0]}}};
        return (old & ~m) | (wd[15:0] & m);
    endfunction : merge

    // Write channel
    logic [ADDR_W-1:0] wa_q;
    logic [31:0] wd_q;
    logic [3:0] ws_q;
    logic we;
    logic wr_hit;
    assign we = !awready && !wready && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            wa_q <= '0;
            wd_q <= '0;
            ws_q <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                wa_q <= awaddr;
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                wd_q <= wdata;
                ws_q <= wstrb;
            end
            if (we) begin
                bvalid <= 1'b1;
                bresp <= wr_hit ? 2'h0 : 2'h2;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    always_comb begin
        case (wa_q)
            OFF_EP_SEL, OFF_TX_KIND, OFF_TX_INTV, OFF_RX_KIND,
            OFF_RX_INTV, OFF_CAPACITY, OFF_VERSION, OFF_EP_INFO,
            OFF_MEM_INFO, OFF_LINK_WAIT, OFF_VBUS_LEN, OFF_HS_GUARD,
            OFF_FS_GUARD, OFF_LS_GUARD, OFF_REQ_COUNT, OFF_TX_SIZING,
            OFF_RX_SIZING, OFF_TX_BASE, OFF_RX_BASE, OFF_CONTROL,
            OFF_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // Global registers
    logic [EPW-1:0] ep_sel_q;
    logic [7:0] link_q, vbus_pulse_duration_q, hs_q, fs_q, ls_q;
    logic [3:0] ctl_q;
    logic [15:0] rq_count_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ep_sel_q <= '0;
            link_q <= RST_LINK_WAIT;
            vbus_pulse_duration_q <= RST_VBUS_LEN;
            hs_q <= RST_HS_GUARD;
            fs_q <= RST_FS_GUARD;
            ls_q <= RST_LS_GUARD;
            ctl_q <= '0;
        end else if (we && ws_q[0]) begin
            // Read-only offsets fall through untouched
            case (wa_q)
                OFF_EP_SEL: ep_sel_q <= wd_q[EPW-1:0];
                OFF_LINK_WAIT: link_q <= wd_q[7:0];
                OFF_VBUS_LEN: vbus_pulse_duration_q <= wd_q[7:0];
                OFF_HS_GUARD: hs_q <= wd_q[7:0];
                OFF_FS_GUARD: fs_q <= wd_q[7:0];
                OFF_LS_GUARD: ls_q <= wd_q[7:0];
                OFF_CONTROL: ctl_q <= wd_q[3:0];
                default: ;
            endcase
        end
    end

    // Live block count, software reload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rq_count_q <= '0;
        end else if (we && wa_q == OFF_REQ_COUNT) begin
            rq_count_q <= merge(rq_count_q, wd_q, ws_q);
        end else if (block_pkt_done && block_req_pending) begin
            rq_count_q <= rq_count_q - 16'h0001;
        end
    end

    // Per-endpoint configuration
    logic [7:0] txk [NUM_EP], txi [NUM_EP], rxk [NUM_EP], rxi [NUM_EP];
    logic [7:0] txs [NUM_EP], rxs [NUM_EP];
    logic [15:0] txb [NUM_EP], rxb [NUM_EP];

    generate
        for (genvar e = 0; e < NUM_EP; e++) begin : g_ep
            logic sel;
            assign sel = we && ws_q[0] && ep_sel_q == EPW'(e);
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    txk[e] <= '0;
                    rxk[e] <= '0;
                    txs[e] <= '0;
                    rxs[e] <= '0;
                end else if (sel) begin
                    if (wa_q == OFF_TX_KIND) txk[e] <= {2'h0, wd_q[5:0]};
                    if (wa_q == OFF_RX_KIND) rxk[e] <= {2'h0, wd_q[5:0]};
                    if (wa_q == OFF_TX_SIZING) txs[e] <= {3'h0, wd_q[4:0]};
                    if (wa_q == OFF_RX_SIZING) rxs[e] <= {3'h0, wd_q[4:0]};
                end
            end
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    txb[e] <= '0;
                    rxb[e] <= '0;
                end else if (we && ep_sel_q == EPW'(e)) begin
                    if (wa_q == OFF_TX_BASE)
                        txb[e] <= merge(txb[e], wd_q, ws_q) & 16'h1FFF;
                    if (wa_q == OFF_RX_BASE)
                        rxb[e] <= merge(rxb[e], wd_q, ws_q) & 16'h1FFF;
                end
            end
            // Endpoint zero has no interval copy
            if (e == 0) begin : g_zero
                assign txi[e] = 8'h00;
                assign rxi[e] = 8'h00;
            end else begin : g_intv
                always_ff @(posedge aclk) begin
                    if (!aresetn) begin
                        txi[e] <= '0;
                        rxi[e] <= '0;
                    end else if (sel) begin
                        if (wa_q == OFF_TX_INTV) txi[e] <= wd_q[7:0];
                        if (wa_q == OFF_RX_INTV) rxi[e] <= wd_q[7:0];
                    end
                end
            end
        end
    endgenerate

    // Sleep and wakeup; pins pass two flops first
    logic [1:0] act_s, res_s;
    logic [31:0] idle_q;
    logic sleep_q, susp_ev_q, res_ev_q, wake_prev_q;
    logic st_clr;
    assign st_clr = we && ws_q[0] && wa_q == OFF_STATUS;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            act_s <= '0;
            res_s <= '0;
        end else begin
            act_s <= {act_s[0], bus_activity};
            res_s <= {res_s[0], resume_signal};
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_q <= '0;
            sleep_q <= 1'b0;
            wake_prev_q <= 1'b0;
        end else begin
            wake_prev_q <= ctl_q[CTL_RESUME];
            if (ctl_q[CTL_HOST] || act_s[1] || sleep_q) begin
                idle_q <= '0;
            end else if (idle_q < 32'(IDLE_CYCLES)) begin
                idle_q <= idle_q + 32'h1;
            end
            if (!sleep_q && !ctl_q[CTL_HOST] && !act_s[1]
                && idle_q == 32'(IDLE_CYCLES - 1)) begin
                sleep_q <= 1'b1;
            end else if (sleep_q && res_s[1]) begin
                sleep_q <= 1'b0;
            end else if (sleep_q && wake_prev_q
                && !ctl_q[CTL_RESUME]) begin
                sleep_q <= 1'b0;
            end
        end
    end

    // A new event beats a same-cycle write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            susp_ev_q <= 1'b0;
            res_ev_q <= 1'b0;
        end else begin
            susp_ev_q <= (susp_ev_q && !(st_clr && wd_q[ST_SUSP_EV]))
                || (!sleep_q && !ctl_q[CTL_HOST] && !act_s[1]
                && idle_q == 32'(IDLE_CYCLES - 1));
            res_ev_q <= (res_ev_q && !(st_clr && wd_q[ST_RESUME_EV]))
                || (sleep_q && res_s[1]);
        end
    end

    // Frame-end guard in whole cycles, rounded down
    logic [31:0] guard_ps;
    always_comb begin
        case (link_speed)
            USBEC_SPD_HIGH: guard_ps = 32'(hs_q) * HS_STEP_PS;
            USBEC_SPD_FULL: guard_ps = 32'(fs_q) * FS_STEP_PS;
            USBEC_SPD_LOW: guard_ps = 32'(ls_q) * LS_STEP_PS;
            default: guard_ps = 32'(ls_q) * LS_STEP_PS;
        endcase
    end

    // Outputs for the engine's endpoint
    logic [7:0] tk, tz, rk, rz;
    assign tk = txk[active_ep];
    assign tz = txs[active_ep];
    assign rk = rxk[active_ep];
    assign rz = rxs[active_ep];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_protocol <= '0;
            tx_target_ep <= '0;
            tx_poll_frames <= '0;
            tx_nak_limit <= '0;
            rx_protocol <= '0;
            rx_target_ep <= '0;
            rx_poll_frames <= '0;
            rx_nak_limit <= '0;
        end else begin
            tx_protocol <= tk[5:4];
            tx_target_ep <= tk[3:0];
            rx_protocol <= rk[5:4];
            rx_target_ep <= rk[3:0];
            tx_poll_frames <= (tk[5:4] == USBEC_PROTO_ISO
                || tk[5:4] == USBEC_PROTO_INTR) ? txi[active_ep] : 8'h00;
            tx_nak_limit <= (tk[5:4] == USBEC_PROTO_BULK)
                ? txi[active_ep] : 8'h00;
            rx_poll_frames <= (rk[5:4] == USBEC_PROTO_ISO
                || rk[5:4] == USBEC_PROTO_INTR) ? rxi[active_ep] : 8'h00;
            rx_nak_limit <= (rk[5:4] == USBEC_PROTO_BULK)
                ? rxi[active_ep] : 8'h00;
        end
    end

    // Codes above 1001 clamp to the largest size
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_max_packet_bytes <= '0;
            tx_buffer_bytes <= '0;
            tx_buffer_byte_addr <= '0;
            rx_max_packet_bytes <= '0;
            rx_buffer_bytes <= '0;
            rx_buffer_byte_addr <= '0;
        end else begin
            tx_max_packet_bytes <= 13'h8 << (tz[3:0] > 4'h9 ? 4'h9 : tz[3:0]);
            rx_max_packet_bytes <= 13'h8 << (rz[3:0] > 4'h9 ? 4'h9 : rz[3:0]);
            tx_buffer_bytes <= (14'h8 << (tz[3:0] > 4'h9 ? 4'h9 : tz[3:0]))
                << tz[DPB_BIT];
            rx_buffer_bytes <= (14'h8 << (rz[3:0] > 4'h9 ? 4'h9 : rz[3:0]))
                << rz[DPB_BIT];
            tx_buffer_byte_addr <= txb[active_ep] << UNIT_SHIFT;
            rx_buffer_byte_addr <= rxb[active_ep] << UNIT_SHIFT;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            txn_start_allowed <= 1'b0;
            block_req_pending <= 1'b0;
            connect_filter_wait <= '0;
            id_settle_delay <= '0;
            vbus_pulse_duration <= '0;
            resume_drive <= 1'b0;
            sleep_active <= 1'b0;
            suspend_indicator_out_n <= 1'b1;
        end else begin
            // Guard blocks starts, never aborts running ones
            txn_start_allowed <= 32'(frame_left_cyc)
                > guard_ps / CLK_PERIOD_PS;
            block_req_pending <= ctl_q[CTL_HOST] && ctl_q[CTL_AUTO_REQ]
                && rq_count_q != 16'h0 && !(block_pkt_done
                && rq_count_q == 16'h1);
            connect_filter_wait <= link_q[7:4];
            id_settle_delay <= link_q[3:0];
            vbus_pulse_duration <= vbus_pulse_duration_q;
            resume_drive <= ctl_q[CTL_RESUME];
            sleep_active <= sleep_q;
            suspend_indicator_out_n <= !(sleep_q
                && ctl_q[CTL_SUSP_EN]);
        end
    end

    // Read channel
    logic [31:0] rd_d;
    logic rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        case (araddr)
            OFF_EP_SEL: rd_d = 32'(ep_sel_q);
            OFF_TX_KIND: rd_d = 32'(txk[ep_sel_q]);
            OFF_TX_INTV: rd_d = 32'(txi[ep_sel_q]);
            OFF_RX_KIND: rd_d = 32'(rxk[ep_sel_q]);
            OFF_RX_INTV: rd_d = 32'(rxi[ep_sel_q]);
            OFF_CAPACITY: rd_d = {24'h0, RX_FIFO_CAP, TX_FIFO_CAP};
            OFF_VERSION: rd_d = {16'h0, VER_RC, VER_MAJOR, VER_MINOR};
            OFF_EP_INFO: rd_d = {24'h0, 4'(NUM_EP), 4'(NUM_EP)};
            OFF_MEM_INFO: rd_d = {24'h0, DMA_CHANS, RAM_BITS_M1};
            OFF_LINK_WAIT: rd_d = 32'(link_q);
            OFF_VBUS_LEN: rd_d = 32'(vbus_pulse_duration_q);
            OFF_HS_GUARD: rd_d = 32'(hs_q);
            OFF_FS_GUARD: rd_d = 32'(fs_q);
            OFF_LS_GUARD: rd_d = 32'(ls_q);
            OFF_REQ_COUNT: rd_d = 32'(rq_count_q);
            OFF_TX_SIZING: rd_d = 32'(txs[ep_sel_q]);
            OFF_RX_SIZING: rd_d = 32'(rxs[ep_sel_q]);
            OFF_TX_BASE: rd_d = 32'(txb[ep_sel_q]);
            OFF_RX_BASE: rd_d = 32'(rxb[ep_sel_q]);
            OFF_CONTROL: rd_d = 32'(ctl_q);
            OFF_STATUS: rd_d = {29'h0, res_ev_q, susp_ev_q, sleep_q};
            default: begin
                rd_d = 32'h0;
                rd_hit = 1'b0;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_d;
            rresp <= rd_hit ? 2'h0 : 2'h2;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule : usbec_top

// ===== usbec_pkg.sv
// Offsets, fields, reset values and timing
package usbec_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_EP_SEL = 8'h00;
    localparam logic [7:0] OFF_TX_KIND = 8'h04;
    localparam logic [7:0] OFF_TX_INTV = 8'h08;
    localparam logic [7:0] OFF_RX_KIND = 8'h0C;
    localparam logic [7:0] OFF_RX_INTV = 8'h10;
    localparam logic [7:0] OFF_CAPACITY = 8'h14;
    localparam logic [7:0] OFF_VERSION = 8'h18;
    localparam logic [7:0] OFF_EP_INFO = 8'h1C;
    localparam logic [7:0] OFF_MEM_INFO = 8'h20;
    localparam logic [7:0] OFF_LINK_WAIT = 8'h24;
    localparam logic [7:0] OFF_VBUS_LEN = 8'h28;
    localparam logic [7:0] OFF_HS_GUARD = 8'h2C;
    localparam logic [7:0] OFF_FS_GUARD = 8'h30;
    localparam logic [7:0] OFF_LS_GUARD = 8'h34;
    localparam logic [7:0] OFF_REQ_COUNT = 8'h38;
    localparam logic [7:0] OFF_TX_SIZING = 8'h3C;
    localparam logic [7:0] OFF_RX_SIZING = 8'h40;
    localparam logic [7:0] OFF_TX_BASE = 8'h44;
    localparam logic [7:0] OFF_RX_BASE = 8'h48;
    localparam logic [7:0] OFF_CONTROL = 8'h4C;
    localparam logic [7:0] OFF_STATUS = 8'h50;
    // Control bits
    localparam int CTL_HOST = 0;
    localparam int CTL_AUTO_REQ = 1;
    localparam int CTL_SUSP_EN = 2;
    localparam int CTL_RESUME = 3;
    // Status bits
    localparam int ST_SLEEP = 0;
    localparam int ST_SUSP_EV = 1;
    localparam int ST_RESUME_EV = 2;
    // Field positions
    localparam int KIND_PROTO_LSB = 4;
    localparam int DPB_BIT = 4;
    localparam int VER_RC_BIT = 15;
    localparam int VER_MAJOR_LSB = 10;
    // Reset values
    localparam logic [7:0] RST_LINK_WAIT = 8'h5C;
    localparam logic [7:0] RST_VBUS_LEN = 8'h3C;
    localparam logic [7:0] RST_HS_GUARD = 8'h80;
    localparam logic [7:0] RST_FS_GUARD = 8'h77;
    localparam logic [7:0] RST_LS_GUARD = 8'h72;
    // Size and address unit as a shift
    localparam int UNIT_SHIFT = 3;
    // Timing
    localparam int CLK_PERIOD_PS = 50000;
    localparam int HS_STEP_PS = 133300;
    localparam int FS_STEP_PS = 533300;
    localparam int LS_STEP_PS = 1067000;
    localparam int IDLE_MS = 3;
    // Scaled down first so the product stays inside 32 bits
    localparam int IDLE_CYC = IDLE_MS * 1000000 / (CLK_PERIOD_PS / 1000);
    typedef enum logic [1:0] {
        USBEC_PROTO_ILLEGAL = 2'b00,
        USBEC_PROTO_ISO = 2'b01,
        USBEC_PROTO_BULK = 2'b10,
        USBEC_PROTO_INTR = 2'b11
    } usbec_proto_t;
    typedef enum logic [1:0] {
        USBEC_SPD_HIGH = 2'b00,
        USBEC_SPD_FULL = 2'b01,
        USBEC_SPD_LOW = 2'b10
    } usbec_speed_t;
endpackage : usbec_pkg

// ===== usbec_checker.sv
// Concurrent checks on the usbec_top ports
module usbec_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus answers
    input wire logic bvalid,
    input wire logic bready,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // Endpoint settings
    input wire logic [1:0] tx_protocol,
    input wire logic [7:0] tx_poll_frames,
    input wire logic [7:0] tx_nak_limit,
    input wire logic [1:0] rx_protocol,
    input wire logic [7:0] rx_poll_frames,
    input wire logic [7:0] rx_nak_limit,
    input wire logic [12:0] tx_max_packet_bytes,
    input wire logic [13:0] tx_buffer_bytes,
    input wire logic [15:0] tx_buffer_byte_addr,
    // Sleep and bus pins
    input wire logic resume_signal,
    input wire logic resume_drive,
    input wire logic sleep_active,
    input wire logic suspend_indicator_out_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Sync flops plus state and output register fit in six edges
    sequence s_wake;
        ##[1:6] !sleep_active;
    endsequence
    property p_b_hold;
        bvalid && !bready |=> bvalid;
    endproperty
    property p_r_hold;
        rvalid && !rready |=> rvalid && $stable(rdata);
    endproperty
    property p_tx_bulk;
        tx_protocol == 2'h2 |-> tx_poll_frames == 8'h00;
    endproperty
    property p_tx_poll;
        tx_protocol[0] |-> tx_nak_limit == 8'h00;
    endproperty
    property p_rx_kind;
        (rx_protocol[0] |-> rx_nak_limit == 8'h00) and
        (rx_protocol == 2'h2 |-> rx_poll_frames == 8'h00);
    endproperty
    property p_pkt;
        $onehot0(tx_max_packet_bytes) && tx_max_packet_bytes[2:0] == 3'h0;
    endproperty
    property p_dbl;
        tx_buffer_bytes == {1'b0, tx_max_packet_bytes} ||
        tx_buffer_bytes == {tx_max_packet_bytes, 1'b0};
    endproperty
    property p_base;
        tx_buffer_byte_addr[2:0] == 3'h0;
    endproperty
    property p_susp;
        !suspend_indicator_out_n |-> sleep_active || $past(sleep_active);
    endproperty
    property p_resume;
        sleep_active && $rose(resume_signal) |-> s_wake;
    endproperty
    property p_wakeup;
        sleep_active && $fell(resume_drive) |-> s_wake;
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
    a_r_hold: assert property (p_r_hold) else $error("read answer moved");
    a_tx_bulk: assert property (p_tx_bulk)
        else $error("bulk tx has poll");
    a_tx_poll: assert property (p_tx_poll)
        else $error("periodic tx has nak");
    a_rx_kind: assert property (p_rx_kind)
        else $error("rx interval split");
    a_pkt: assert property (p_pkt) else $error("packet size");
    a_dbl: assert property (p_dbl) else $error("buffer size");
    a_base: assert property (p_base) else $error("base unit");
    a_susp: assert property (p_susp) else $error("suspend out");
    a_resume: assert property (p_resume) else $error("no wake");
    a_wakeup: assert property (p_wakeup) else $error("no rwake");
endmodule : usbec_checker

bind usbec_top usbec_checker u_chk (.*);

// ===== usbec_usb_peer.sv
// Upstream USB port model
module usbec_usb_peer (
    // Clock
    input wire logic aclk,
    // Scenario controls
    input wire logic talk,
    input wire logic wake,
    // Bus lines
    output logic bus_activity,
    output logic resume_signal
);
    // Traffic toggles the line so every cycle shows an edge
    always @(posedge aclk) begin
        bus_activity <= talk & ~bus_activity;
        resume_signal <= wake;
    end
endmodule : usbec_usb_peer

// ===== usbec_tb_top.sv
// Self-checking bench for usbec_top
module usbec_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import usbec_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} usbec_row_t;
    localparam int IDLE = 20;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, block_pkt_done = 1'b0;
    logic talk = 1'b1, wake = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0, tx_target_ep, rx_target_ep;
    logic [3:0] connect_filter_wait, id_settle_delay;
    logic [1:0] active_ep = 2'h0, bresp, rresp, rs, tx_protocol, rx_protocol;
    usbec_speed_t link_speed = USBEC_SPD_HIGH;
    logic [15:0] frame_left_cyc = 16'h0, tx_buffer_byte_addr;
    logic [15:0] rx_buffer_byte_addr;
    logic awready, wready, bvalid, arready, rvalid, txn_start_allowed;
    logic block_req_pending, bus_activity, resume_signal, resume_drive;
    logic sleep_active, suspend_indicator_out_n;
    logic [7:0] tx_poll_frames, tx_nak_limit, rx_poll_frames, rx_nak_limit;
    logic [7:0] vbus_pulse_duration;
    logic [12:0] tx_max_packet_bytes, rx_max_packet_bytes;
    logic [13:0] tx_buffer_bytes, rx_buffer_bytes;
    int fail_count = 0, comparisons = 0, n, g;
    int step [3] = '{HS_STEP_PS, FS_STEP_PS, LS_STEP_PS};
    logic [7:0] goff [3] = '{OFF_HS_GUARD, OFF_FS_GUARD, OFF_LS_GUARD};
    logic [7:0] roff [6] = '{OFF_LINK_WAIT, OFF_VBUS_LEN, OFF_HS_GUARD,
        OFF_FS_GUARD, OFF_LS_GUARD, OFF_RX_KIND};
    logic [7:0] rval [6] = '{RST_LINK_WAIT, RST_VBUS_LEN, RST_HS_GUARD,
        RST_FS_GUARD, RST_LS_GUARD, 8'h00};
    usbec_row_t rows [15] = '{'{OFF_TX_KIND, 'h36, 'h36},
        '{OFF_TX_INTV, 'hA5, 'hA5}, '{OFF_RX_KIND, 'h2F, 'h2F},
        '{OFF_RX_INTV, 'h07, 'h07}, '{OFF_CAPACITY, 'hFF, 'h33},
        '{OFF_VERSION, 'hFFFF, 'h0400}, '{OFF_EP_INFO, 'hFF, 'h44},
        '{OFF_MEM_INFO, 'hFF, 'h0B}, '{OFF_LINK_WAIT, 'hA7, 'hA7},
        '{OFF_VBUS_LEN, 'h81, 'h81}, '{OFF_REQ_COUNT, 'h1234, 'h1234},
        '{OFF_TX_SIZING, 'h19, 'h19}, '{OFF_RX_SIZING, 'h03, 'h03},
        '{OFF_TX_BASE, 'hFFFF, 'h1FFF}, '{OFF_RX_BASE, 'h01, 'h01}};
    always #25 aclk = ~aclk;
    usbec_top #(.IDLE_CYCLES(IDLE)) uut (.*, .awprot(3'h0), .arprot(3'h0));
    usbec_usb_peer peer (.*);
    task automatic wrap_up;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(input string nm, input logic [31:0] e, logic [31:0] v);
        comparisons++;
        if (v !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, e, v);
        end
    endtask : chk
    task automatic lost(input int k);
        if (k >= 60) begin
            fail_count++;
            wrap_up();
        end
    endtask : lost
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 60; k++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        rs = bresp;
        bready <= 1'b0;
        lost(k);
    endtask : wr
    task automatic rd_reg(input logic [7:0] a);
        int k;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 60; k++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        lost(k);
    endtask : rd_reg
    task automatic wait_sleep(input logic e);
        for (n = 0; n < 60; n++) begin
            @(posedge aclk);
            if (sleep_active === e) break;
        end
        lost(n);
    endtask : wait_sleep
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        wr(OFF_EP_SEL, 32'h1);
        active_ep <= 2'h1;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rd_reg(rows[i].a);
            chk("reg", rows[i].e, rd);
        end
        chk("tx", {2'h3, 4'h6, 16'hA500}, {tx_protocol, tx_target_ep,
            tx_poll_frames, tx_nak_limit});
        chk("rx", {2'h2, 4'hF, 16'h0007}, {rx_protocol, rx_target_ep,
            rx_poll_frames, rx_nak_limit});
        chk("txbuf", {13'd4096, 14'd8192},
            {tx_max_packet_bytes, tx_buffer_bytes});
        chk("rxbuf", {13'd64, 14'd64},
            {rx_max_packet_bytes, rx_buffer_bytes});
        chk("base", 32'hFFF8_0008,
            {tx_buffer_byte_addr, rx_buffer_byte_addr});
        chk("link", 32'hA781, {connect_filter_wait, id_settle_delay,
            vbus_pulse_duration});
        for (int c = 0; c < 4; c++) begin
            wr(OFF_TX_KIND, {c[1:0], 4'h6});
            repeat (2) @(posedge aclk);
            chk("poll", c[0] ? 32'hA5 : 32'h0, tx_poll_frames);
            chk("nak", c == 2 ? 32'hA5 : 32'h0, tx_nak_limit);
        end
        wr(8'hFC, 32'h1);
        chk("bresp", 32'h2, rs);
        rd_reg(8'hFC);
        chk("rresp", 32'h2, {rd, rs});
        for (int s = 0; s < 3; s++) begin
            g = 15 * step[s] / CLK_PERIOD_PS;
            wr(goff[s], 32'h0F);
            link_speed <= usbec_speed_t'(s);
            frame_left_cyc <= g[15:0];
            repeat (3) @(posedge aclk);
            chk("guard", 32'h0, txn_start_allowed);
            frame_left_cyc <= g[15:0] + 16'h1;
            repeat (3) @(posedge aclk);
            chk("open", 32'h1, txn_start_allowed);
        end
        wr(OFF_REQ_COUNT, 32'h1);
        wr(OFF_CONTROL, 32'h3);
        repeat (2) @(posedge aclk);
        chk("pend", 32'h1, block_req_pending);
        block_pkt_done <= 1'b1;
        @(posedge aclk);
        block_pkt_done <= 1'b0;
        repeat (2) @(posedge aclk);
        chk("done", 32'h0, block_req_pending);
        wr(OFF_REQ_COUNT, 32'h5);
        wr(OFF_CONTROL, 32'h1);
        talk <= 1'b0;
        repeat (3 * IDLE) @(posedge aclk);
        chk("noreq", 32'h0, {block_req_pending, sleep_active});
        talk <= 1'b1;
        wr(OFF_CONTROL, 32'h4);
        talk <= 1'b0;
        wait_sleep(1'b1);
        chk("idle", 32'h1, n >= IDLE && n <= IDLE + 8);
        rd_reg(OFF_STATUS);
        chk("stat", 32'h6, {rd[2:0], suspend_indicator_out_n});
        wake <= 1'b1;
        wait_sleep(1'b0);
        wake <= 1'b0;
        rd_reg(OFF_STATUS);
        chk("res", 32'h1, rd[ST_RESUME_EV]);
        wait_sleep(1'b1);
        wr(OFF_CONTROL, 32'hC);
        repeat (10) @(posedge aclk);
        chk("held", 32'h3, {resume_drive, sleep_active});
        wr(OFF_CONTROL, 32'h4);
        wait_sleep(1'b0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (roff[i]) begin
            rd_reg(roff[i]);
            chk("reset", rval[i], rd);
        end
        wrap_up();
    end
endmodule : usbec_tb_top
